//--- design/sfbpt_flash.sv
`timescale 1ns/1ps
`default_nettype none

// Flash end: answers discovery reads with the basic parameter table.
module sfbpt_flash #(
    parameter logic [31:0] DENSITY = 32'hFFFF_FFFF
) (
    // Clock, reset and enable.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Serial link.
    sfbpt_link_if.flash      link,
    // Status toward local logic.
    output logic             active_o,
    output logic [23:0]      cur_addr_o
);

    typedef enum {
        SFBPT_CMD,
        SFBPT_ADDR,
        SFBPT_DUMMY,
        SFBPT_DATA,
        SFBPT_IGNORE
    } sfbpt_dev_state_t;

    // Returns the table byte at a discovery address; anything outside reads as unused.
    // Bytes 34H to 37H carry the density word, least significant byte first.
    function automatic logic [7:0] sfbpt_byte(input logic [23:0] a);
        logic [7:0] b;
        b = sfbpt_pkg::UNUSED_BYTE; // RULE4
        if (a >= sfbpt_pkg::TABLE_BASE && a <= sfbpt_pkg::TABLE_LAST) begin // RULE20
            case (a[7:0])
                8'h30: begin
                    b = {sfbpt_pkg::UNUSED3, sfbpt_pkg::VOL_WREN_OPSEL, // RULE4
                         sfbpt_pkg::VOL_WREN_REQ, // RULE3
                         sfbpt_pkg::WRITE_GRAN_64, // RULE2
                         sfbpt_pkg::ERASE_SIZE_4K}; // RULE1
                end
                8'h31: b = sfbpt_pkg::ERASE_4K_OPCODE; // RULE15
                8'h32: begin
                    b = {sfbpt_pkg::UNUSED1, sfbpt_pkg::QUAD_OUT_SUPPORT,
                         sfbpt_pkg::QUAD_IO_SUPPORT, sfbpt_pkg::DUAL_IO_SUPPORT,
                         sfbpt_pkg::DTR_SUPPORT, // RULE6
                         sfbpt_pkg::ADDR_BYTES_3ONLY, // RULE5
                         sfbpt_pkg::DUAL_OUT_SUPPORT};
                end
                8'h34, 8'h35, 8'h36, 8'h37: begin
                    b = 8'(DENSITY >> {a[1:0] - sfbpt_pkg::DENSITY_BASE[1:0], 3'h0});
                end
                8'h38: b = {sfbpt_pkg::QIO_MODE, sfbpt_pkg::QIO_WAIT}; // RULE9
                8'h39: b = sfbpt_pkg::QIO_OPCODE; // RULE9
                8'h3A: b = {sfbpt_pkg::QOUT_MODE, sfbpt_pkg::QOUT_WAIT}; // RULE10
                8'h3B: b = sfbpt_pkg::QOUT_OPCODE; // RULE10
                8'h3C: b = {sfbpt_pkg::DOUT_MODE, sfbpt_pkg::DOUT_WAIT}; // RULE11
                8'h3D: b = sfbpt_pkg::DOUT_OPCODE; // RULE11
                8'h3E: b = {sfbpt_pkg::DIO_MODE, sfbpt_pkg::DIO_WAIT}; // RULE12
                8'h3F: b = sfbpt_pkg::DIO_OPCODE; // RULE12
                8'h40: begin
                    b = {sfbpt_pkg::UNUSED3, sfbpt_pkg::QPI_444_SUPPORT, // RULE13
                         sfbpt_pkg::UNUSED3, sfbpt_pkg::QPI_222_SUPPORT}; // RULE13
                end
                8'h46, 8'h4A: b = {sfbpt_pkg::NONE_MODE, sfbpt_pkg::NONE_WAIT}; // RULE7 RULE8
                8'h47, 8'h4B: b = sfbpt_pkg::NONE_OPCODE; // RULE13
                8'h4C: b = sfbpt_pkg::SECT1_EXP; // RULE14 RULE15
                8'h4D: b = sfbpt_pkg::SECT1_OPCODE; // RULE15
                8'h4E: b = sfbpt_pkg::SECT2_EXP; // RULE16
                8'h4F: b = sfbpt_pkg::SECT2_OPCODE; // RULE16
                8'h50: b = sfbpt_pkg::SECT3_EXP; // RULE17
                8'h51: b = sfbpt_pkg::SECT3_OPCODE; // RULE17
                8'h52: b = sfbpt_pkg::SECT4_EXP; // RULE18
                8'h53: b = sfbpt_pkg::SECT4_OPCODE; // RULE18
                default: b = sfbpt_pkg::UNUSED_BYTE; // RULE4
            endcase
        end
        return b;
    endfunction

    sfbpt_dev_state_t state_reg;
    logic             sclk_prev_reg;
    logic [4:0]       bit_cnt_reg;
    logic [23:0]      shin_reg;
    logic [23:0]      addr_reg;
    logic [2:0]       out_bit_reg;
    logic [6:0]       out_sh_reg;
    logic             miso_reg;
    logic             miso_oe_reg;
    logic             active_reg;

    // Edge decode of the serial clock while selected.
    // The serial clock is a host register on the same system clock, so a one-cycle
    // history is enough; mosi is read one cycle after the host raises the clock.
    wire              selected   = ~link.cs_n;
    wire              sclk_rise  = selected & link.sclk & ~sclk_prev_reg;
    wire              sclk_fall  = selected & ~link.sclk & sclk_prev_reg;
    wire  [23:0]      shin_next  = {shin_reg[22:0], link.mosi};
    wire  [4:0]       bit_cnt_inc = bit_cnt_reg + 5'h01;
    wire              cmd_done   = bit_cnt_reg == sfbpt_pkg::CMD_LAST_BIT;
    wire              addr_done  = bit_cnt_reg == sfbpt_pkg::ADDR_LAST_BIT;
    wire              dummy_done = bit_cnt_reg == sfbpt_pkg::DUMMY_LAST_BIT;
    wire              cmd_match  = shin_next[7:0] == sfbpt_pkg::READ_DISCOVERY_TABLE_CMD;
    wire  [7:0]       table_byte = sfbpt_byte(addr_reg);
    wire              first_bit  = out_bit_reg == 3'h0;

    // Serial clock history.
    // It resets to the idle low level so that no false rise follows reset.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sclk_prev_reg <= 1'b0;
        end else if (ce_i) begin
            sclk_prev_reg <= link.sclk;
        end
    end

    // Command, address and dummy phases sampled on rising serial clock.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= SFBPT_CMD;
            bit_cnt_reg <= 5'h00;
            shin_reg    <= 24'h000000;
            active_reg  <= 1'b0;
        end else if (ce_i) begin
            if (link.cs_n) begin
                state_reg   <= SFBPT_CMD;
                bit_cnt_reg <= 5'h00;
                active_reg  <= 1'b0;
            end else if (sclk_rise) begin
                shin_reg    <= shin_next;
                bit_cnt_reg <= bit_cnt_inc;
                case (state_reg)
                    SFBPT_CMD: begin
                        if (cmd_done) begin
                            bit_cnt_reg <= 5'h00;
                            state_reg   <= cmd_match ? SFBPT_ADDR : SFBPT_IGNORE; // RULE19
                            active_reg  <= cmd_match;
                        end
                    end
                    SFBPT_ADDR: begin
                        if (addr_done) begin
                            bit_cnt_reg <= 5'h00;
                            state_reg   <= SFBPT_DUMMY; // RULE19
                        end
                    end
                    SFBPT_DUMMY: begin
                        if (dummy_done) begin
                            bit_cnt_reg <= 5'h00;
                            state_reg   <= SFBPT_DATA; // RULE19
                        end
                    end
                    SFBPT_DATA, SFBPT_IGNORE: begin
                        bit_cnt_reg <= 5'h00;
                    end
                    default: state_reg <= SFBPT_IGNORE;
                endcase
            end
        end
    end

    // Start address capture and increment after each byte handed out.
    // The address moves on as each byte starts and the closing fall starts one more, so it ends two past the last byte read.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_reg <= 24'h000000;
        end else if (ce_i) begin
            if (sclk_rise && state_reg == SFBPT_ADDR && addr_done) begin
                addr_reg <= shin_next;
            end else if (sclk_fall && state_reg == SFBPT_DATA && first_bit) begin
                addr_reg <= addr_reg + 24'h000001; // RULE21
            end
        end
    end

    // Data bits leave on falling serial clock, most significant first.
    // The output enable drops one cycle after deselect; the link's pull-up then reads ones.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_bit_reg <= 3'h0;
            out_sh_reg  <= 7'h7F;
            miso_reg    <= 1'b1;
            miso_oe_reg <= 1'b0;
        end else if (ce_i) begin
            if (state_reg != SFBPT_DATA || link.cs_n) begin
                out_bit_reg <= 3'h0;
                miso_oe_reg <= 1'b0;
            end else if (sclk_fall) begin
                miso_oe_reg <= 1'b1;
                out_bit_reg <= out_bit_reg + 3'h1;
                if (first_bit) begin
                    miso_reg   <= table_byte[7]; // RULE21
                    out_sh_reg <= table_byte[6:0];
                end else begin
                    miso_reg   <= out_sh_reg[6]; // RULE21
                    out_sh_reg <= {out_sh_reg[5:0], 1'b1};
                end
            end
        end
    end

    // Outputs straight from flip-flops.
    // Status outputs let local logic see an open read and its position.
    assign link.miso_dat = miso_reg;
    assign link.miso_oe  = miso_oe_reg;
    assign active_o      = active_reg;
    assign cur_addr_o    = addr_reg;

endmodule // sfbpt_flash

`default_nettype wire

//--- common/sfbpt_pkg.sv
// Functional notes
// (RULE1) Erase size field reads 01b, 4 KB.
// (RULE2) Write granularity bit reads 1b, 64 bytes.
// (RULE3) Volatile write-enable bits 3 and 4 read 00b.
// (RULE4) Unused fields and bytes read all ones.
// (RULE5) Address width field reads 00b, 3-byte.
// (RULE6) Double transfer rate bit reads 0b.
// (RULE7) Zero wait states means no dummy clocks.
// (RULE8) Zero mode bits means no mode clocks.
// (RULE9) Quad I/O read: EBh, 4 dummy, 2 mode.
// (RULE10) Quad output read: 6BH, 8 dummy, none.
// (RULE11) Dual output read: 3Bh, 8 dummy, none.
// (RULE12) Dual I/O read: BBh, 0 dummy, 4 mode.
// (RULE13) 2-2-2 and 4-4-4 reads declared unsupported.
// (RULE14) Sector size byte is power-of-two exponent.
// (RULE15) Sector 1: 4 KB, opcode 20H, also 31H.
// (RULE16) Sector 2: 32 KB, opcode 52H.
// (RULE17) Sector 3: 64 KB, opcode D8H.
// (RULE18) Sector 4: 256 bytes, opcode 81H.
// (RULE19) Read: 5Ah, 3 address, 1 dummy, data.
// (RULE20) Basic table starts at address 30H.
// (RULE21) Bytes stream MSB first, address incrementing.
package sfbpt_pkg;

    // Link command framing.
    localparam logic [7:0]  READ_DISCOVERY_TABLE_CMD = 8'h5A;
    localparam logic [7:0]  DUMMY_BYTE               = 8'h00;
    localparam logic [4:0]  CMD_LAST_BIT             = 5'h07;
    localparam logic [4:0]  ADDR_LAST_BIT            = 5'h17;
    localparam logic [4:0]  DUMMY_LAST_BIT           = 5'h07;
    localparam logic [5:0]  HEAD_LAST_BIT            = 6'h27;
    localparam logic [2:0]  BYTE_LAST_BIT            = 3'h7;
    localparam logic [7:0]  UNUSED_BYTE              = 8'hFF;

    // Serial clock half period and its count of system clocks at 40 ns.
    localparam int          CLK_PERIOD_NS            = 40;
    localparam int          SCLK_HALF_NS             = 80;
    localparam logic [3:0]  SCLK_HALF_CYC            = 4'((SCLK_HALF_NS + CLK_PERIOD_NS - 1)
                                                          / CLK_PERIOD_NS);

    // Table placement.
    localparam logic [23:0] TABLE_BASE               = 24'h000030;
    localparam logic [23:0] TABLE_LAST               = 24'h000053;
    localparam logic [23:0] DENSITY_BASE             = 24'h000034;

    // Byte 30H fields and the byte 31H erase opcode.
    localparam logic [1:0]  ERASE_SIZE_4K            = 2'h1;
    localparam logic        WRITE_GRAN_64            = 1'b1;
    localparam logic        VOL_WREN_REQ             = 1'b0;
    localparam logic        VOL_WREN_OPSEL           = 1'b0;
    localparam logic [2:0]  UNUSED3                  = 3'h7;
    localparam logic [7:0]  ERASE_4K_OPCODE          = 8'h20;

    // Byte 32H fields.
    localparam logic        DUAL_OUT_SUPPORT         = 1'b1;
    localparam logic [1:0]  ADDR_BYTES_3ONLY         = 2'h0;
    localparam logic        DTR_SUPPORT              = 1'b0;
    localparam logic        DUAL_IO_SUPPORT          = 1'b1;
    localparam logic        QUAD_IO_SUPPORT          = 1'b1;
    localparam logic        QUAD_OUT_SUPPORT         = 1'b1;
    localparam logic        UNUSED1                  = 1'b1;

    // Fast-read entries: wait states (zero means none) and mode bits (zero means none).
    localparam logic [4:0]  QIO_WAIT                 = 5'h04;
    localparam logic [2:0]  QIO_MODE                 = 3'h2;
    localparam logic [7:0]  QIO_OPCODE               = 8'hEB;
    localparam logic [4:0]  QOUT_WAIT                = 5'h08;
    localparam logic [2:0]  QOUT_MODE                = 3'h0;
    localparam logic [7:0]  QOUT_OPCODE              = 8'h6B;
    localparam logic [4:0]  DOUT_WAIT                = 5'h08;
    localparam logic [2:0]  DOUT_MODE                = 3'h0;
    localparam logic [7:0]  DOUT_OPCODE              = 8'h3B;
    localparam logic [4:0]  DIO_WAIT                 = 5'h00;
    localparam logic [2:0]  DIO_MODE                 = 3'h4;
    localparam logic [7:0]  DIO_OPCODE               = 8'hBB;

    // Unsupported 2-2-2 and 4-4-4 modes.
    localparam logic        QPI_222_SUPPORT          = 1'b0;
    localparam logic        QPI_444_SUPPORT          = 1'b0;
    localparam logic [4:0]  NONE_WAIT                = 5'h00;
    localparam logic [2:0]  NONE_MODE                = 3'h0;
    localparam logic [7:0]  NONE_OPCODE              = 8'hFF;

    // Erase sector types: size exponent and opcode.
    localparam logic [7:0]  SECT1_EXP                = 8'h0C;
    localparam logic [7:0]  SECT1_OPCODE             = 8'h20;
    localparam logic [7:0]  SECT2_EXP                = 8'h0F;
    localparam logic [7:0]  SECT2_OPCODE             = 8'h52;
    localparam logic [7:0]  SECT3_EXP                = 8'h10;
    localparam logic [7:0]  SECT3_OPCODE             = 8'hD8;
    localparam logic [7:0]  SECT4_EXP                = 8'h08;
    localparam logic [7:0]  SECT4_OPCODE             = 8'h81;

endpackage : sfbpt_pkg

//--- common/sfbpt_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// Serial link between the table reader and the flash end.
interface sfbpt_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso_dat;
    logic miso_oe;
    logic miso;

    // Data-out line floats high through a pull-up when the flash end does not drive it.
    assign miso = miso_oe ? miso_dat : 1'b1;

    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input  miso
    );

    modport flash (
        input  cs_n,
        input  sclk,
        input  mosi,
        output miso_dat,
        output miso_oe
    );
endinterface : sfbpt_link_if

`default_nettype wire

//--- design/sfbpt_host.sv
`timescale 1ns/1ps
`default_nettype none

// Host end: issues one discovery read and returns the bytes it gets.
module sfbpt_host (
    // Clock, reset and enable.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Request.
    input  wire logic        start_i,
    input  wire logic [23:0] addr_i,
    input  wire logic [7:0]  count_i,
    // Answer.
    output logic             busy_o,
    output logic             rd_valid_o,
    output logic [7:0]       rd_data_o,
    output logic             done_o,
    // Serial link.
    sfbpt_link_if.host       link
);

    typedef enum {
        SFBPT_IDLE,
        SFBPT_HEAD,
        SFBPT_READ,
        SFBPT_FINISH
    } sfbpt_host_state_t;

    sfbpt_host_state_t state_reg;
    logic [3:0]        div_reg;
    logic [38:0]       out_sh_reg;
    logic [10:0]       bit_cnt_reg;
    logic [10:0]       total_reg;
    logic [7:0]        in_sh_reg;
    logic              cs_n_reg;
    logic              sclk_reg;
    logic              mosi_reg;
    logic              busy_reg;
    logic              valid_reg;
    logic [7:0]        data_reg;
    logic              done_reg;

    // Divider tick and phase decode.
    wire               tick      = div_reg == sfbpt_pkg::SCLK_HALF_CYC - 4'h1;
    wire  [7:0]        in_next   = {in_sh_reg[6:0], link.miso};
    wire               head_end  = bit_cnt_reg[5:0] == sfbpt_pkg::HEAD_LAST_BIT;
    wire               byte_end  = bit_cnt_reg[2:0] == sfbpt_pkg::BYTE_LAST_BIT;
    wire  [10:0]       bit_inc   = bit_cnt_reg + 11'h001;
    wire               go        = state_reg == SFBPT_IDLE && start_i;

    // Serial clock divider runs only inside a frame.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 4'h0;
        end else if (ce_i) begin
            div_reg <= (state_reg == SFBPT_IDLE || tick) ? 4'h0 : div_reg + 4'h1;
        end
    end

    // Frame sequencer: command, address, dummy, then the requested bytes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= SFBPT_IDLE;
            out_sh_reg  <= 39'h0;
            bit_cnt_reg <= 11'h000;
            total_reg   <= 11'h000;
            in_sh_reg   <= 8'h00;
            cs_n_reg    <= 1'b1;
            sclk_reg    <= 1'b0;
            mosi_reg    <= 1'b0;
            busy_reg    <= 1'b0;
            valid_reg   <= 1'b0;
            data_reg    <= 8'h00;
            done_reg    <= 1'b0;
        end else if (ce_i) begin
            valid_reg <= 1'b0;
            done_reg  <= 1'b0;
            case (state_reg)
                SFBPT_IDLE: begin
                    if (go) begin
                        state_reg   <= SFBPT_HEAD;
                        cs_n_reg    <= 1'b0;
                        busy_reg    <= 1'b1;
                        bit_cnt_reg <= 11'h000;
                        total_reg   <= {count_i, 3'h0};
                        mosi_reg    <= sfbpt_pkg::READ_DISCOVERY_TABLE_CMD[7]; // RULE19
                        out_sh_reg  <= {sfbpt_pkg::READ_DISCOVERY_TABLE_CMD[6:0], // RULE19
                                        addr_i, sfbpt_pkg::DUMMY_BYTE};
                    end
                end
                SFBPT_HEAD: begin
                    if (tick && !sclk_reg) begin
                        sclk_reg <= 1'b1;
                    end else if (tick) begin
                        sclk_reg    <= 1'b0;
                        bit_cnt_reg <= bit_inc;
                        mosi_reg    <= out_sh_reg[38];
                        out_sh_reg  <= {out_sh_reg[37:0], 1'b0};
                        if (head_end) begin
                            bit_cnt_reg <= 11'h000;
                            state_reg   <= (total_reg == 11'h000) ? SFBPT_FINISH : SFBPT_READ;
                        end
                    end
                end
                SFBPT_READ: begin
                    if (tick && !sclk_reg) begin
                        sclk_reg    <= 1'b1;
                        in_sh_reg   <= in_next;
                        bit_cnt_reg <= bit_inc;
                        if (byte_end) begin
                            valid_reg <= 1'b1;
                            data_reg  <= in_next;
                        end
                    end else if (tick) begin
                        sclk_reg <= 1'b0;
                        if (bit_cnt_reg == total_reg) begin
                            state_reg <= SFBPT_FINISH;
                        end
                    end
                end
                SFBPT_FINISH: begin
                    if (tick) begin
                        cs_n_reg  <= 1'b1;
                        busy_reg  <= 1'b0;
                        done_reg  <= 1'b1;
                        state_reg <= SFBPT_IDLE;
                    end
                end
                default: state_reg <= SFBPT_IDLE;
            endcase
        end
    end

    // Outputs straight from flip-flops.
    assign link.cs_n  = cs_n_reg;
    assign link.sclk  = sclk_reg;
    assign link.mosi  = mosi_reg;
    assign busy_o     = busy_reg;
    assign rd_valid_o = valid_reg;
    assign rd_data_o  = data_reg;
    assign done_o     = done_reg;

endmodule // sfbpt_host

`default_nettype wire

//--- dv/sfbpt_asserts.sv
`timescale 1ns/1ps
`default_nettype none

// Watches the serial link between the table reader and the flash end.
module sfbpt_asserts (
    // Clock, reset and enable.
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // Link signals.
    input  wire logic cs_n,
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic miso_dat,
    input  wire logic miso_oe,
    input  wire logic miso
);
    logic       sclk_reg;
    logic [9:0] rise_reg;
    logic [7:0] cmd_reg;
    logic       rise_seen;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A serial clock rise inside a frame.
    assign rise_seen = sclk && !sclk_reg && !cs_n;

    // Counts rises in the frame and keeps the first byte the reader sent.
    always_ff @(posedge clk_i) begin
        sclk_reg <= sclk;
        if (rst_i || cs_n) begin
            rise_reg <= 10'h000;
        end else if (rise_seen) begin
            rise_reg <= rise_reg + 10'h001;
        end
        if (rise_seen && rise_reg < 10'h008) begin
            cmd_reg <= {cmd_reg[6:0], mosi};
        end
    end

    oe_release_a: assert property (disable iff (rst_i || !ce_i) $rose(cs_n) |=> !miso_oe)
        else $error("flash still drives data after deselect");
    clock_framed_a: assert property (sclk |-> !cs_n)
        else $error("serial clock high outside a frame");
    sclk_high_two_a: assert property (disable iff (rst_i || !ce_i)
        $rose(sclk) |=> sclk ##1 !sclk)
        else $error("serial clock high phase is not two cycles");
    mosi_on_low_a: assert property (!cs_n && $changed(mosi) |-> !sclk)
        else $error("command line changed while serial clock high");
    miso_steady_a: assert property (miso_oe && sclk && $past(sclk)
        |-> $stable(miso) && miso == miso_dat)
        else $error("data line changed while serial clock high");
    answer_after_head_a: assert property ($rose(miso_oe)
        |-> rise_reg >= 10'd40 && rise_reg <= 10'd41)
        else $error("answer started before the 40 header clocks");
    answer_cmd_a: assert property ($rose(miso_oe) |-> cmd_reg == 8'h5A)
        else $error("answer given to a wrong command byte");
    whole_bytes_a: assert property ($rose(cs_n) && rise_reg >= 10'd40
        |-> rise_reg[2:0] == 3'h0)
        else $error("frame ended inside a byte");

    // Main scenarios: an answer, a header-only frame, back-to-back frames.
    answer_c: cover property ($rose(miso_oe));
    header_only_c: cover property ($rose(cs_n) && rise_reg == 10'd40);
    back_to_back_c: cover property ($rose(cs_n) ##1 $fell(cs_n));
endmodule // sfbpt_asserts

`default_nettype wire

//--- dv/sfdp_basic_param_table_bench.sv
`timescale 1ns/1ps
`default_nettype none

// Reads the parameter table through the host end and checks every byte.
module sfdp_basic_param_table_bench;
    localparam logic [31:0] DENS = 32'hA5C3_0F96;

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        ce_i = 1'b1;
    logic        start_i = 1'b0;
    logic [23:0] addr_i = 24'h000000;
    logic [7:0]  count_i = 8'h00;
    logic        busy_o;
    logic        rd_valid_o;
    logic [7:0]  rd_data_o;
    logic        done_o;
    logic        active_o;
    logic [23:0] cur_addr_o;
    logic        sclk_q = 1'b0;
    logic [9:0]  nrise = 10'h000;
    logic [7:0]  wire_cmd = 8'h00;
    logic [7:0]  wire_dat = 8'h00;
    int          fails = 0;
    int          cmp_count = 0;

    sfbpt_link_if link ();

    sfbpt_host u_sfbpt_host (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .start_i(start_i), .addr_i(addr_i),
        .count_i(count_i), .busy_o(busy_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
        .done_o(done_o), .link(link)
    );

    sfbpt_flash #(.DENSITY(DENS)) u_sfbpt_flash (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .link(link),
        .active_o(active_o), .cur_addr_o(cur_addr_o)
    );

    sfbpt_asserts u_sfbpt_asserts (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cs_n(link.cs_n), .sclk(link.sclk),
        .mosi(link.mosi), .miso_dat(link.miso_dat), .miso_oe(link.miso_oe), .miso(link.miso)
    );

    // Clock at 25 MHz.
    always #20 clk_i = ~clk_i;

    // Captures the command byte and the first answered byte off the wire.
    always @(posedge clk_i) begin
        sclk_q <= link.sclk;
        if (link.cs_n) begin
            nrise <= 10'h000;
        end else if (link.sclk && !sclk_q) begin
            nrise <= nrise + 10'h001;
            if (nrise < 10'd8) wire_cmd <= {wire_cmd[6:0], link.mosi};
            if (nrise >= 10'd40 && nrise < 10'd48) wire_dat <= {wire_dat[6:0], link.miso};
        end
    end

    // Expected table content by discovery address.
    function automatic logic [7:0] exp_byte(input logic [23:0] a);
        if (a >= 24'h34 && a <= 24'h37) return DENS[8 * (a - 24'h34) +: 8];
        case (a)
            24'h30: return {3'h7, 1'b0, 1'b0, 1'b1, 2'h1};
            24'h31: return 8'h20;
            24'h32: return {4'hF, 1'b0, 2'h0, 1'b1};
            24'h38: return {3'h2, 5'h04};
            24'h39: return 8'hEB;
            24'h3A: return {3'h0, 5'h08};
            24'h3B: return 8'h6B;
            24'h3C: return {3'h0, 5'h08};
            24'h3D: return 8'h3B;
            24'h3E: return {3'h4, 5'h00};
            24'h3F: return 8'hBB;
            24'h40: return {3'h7, 1'b0, 3'h7, 1'b0};
            24'h46: return {3'h0, 5'h00};
            24'h4A: return {3'h0, 5'h00};
            24'h4C: return 8'h0C;
            24'h4D: return 8'h20;
            24'h4E: return 8'h0F;
            24'h4F: return 8'h52;
            24'h50: return 8'h10;
            24'h51: return 8'hD8;
            24'h52: return 8'h08;
            24'h53: return 8'h81;
            default: return 8'hFF;
        endcase
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One discovery read; the enable drops for six cycles at cycle stall.
    task automatic rd(input logic [23:0] a, input logic [7:0] n, input int stall);
        int cyc;
        int got;
        cyc = 0;
        got = 0;
        addr_i = a;
        count_i = n;
        start_i = 1'b1;
        @(posedge clk_i);
        #1;
        start_i = 1'b0;
        check({7'h00, busy_o}, 8'h01);
        while (cyc < 4000) begin
            if (cyc == stall) ce_i = 1'b0;
            if (cyc == stall + 6) ce_i = 1'b1;
            if (rd_valid_o === 1'b1) begin
                if (got == 0) check({7'h00, active_o}, 8'h01);
                check(rd_data_o, exp_byte(a + 24'(got)));
                got++;
            end
            if (done_o === 1'b1) break;
            @(posedge clk_i);
            #1;
            cyc++;
        end
        check(8'(got), n);
        check({7'h00, done_o}, 8'h01);
        check(cur_addr_o[7:0], 8'(a + 24'(n) + 24'h000001));
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        test_done();
    end

    // Reset, then the read sequence.
    initial begin
        repeat (3) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        rd(24'h30, 8'd36, 100);
        check(wire_cmd, 8'h5A);
        check(wire_dat, 8'hE5);
        rd(24'h52, 8'd4, -10);
        rd(24'h2E, 8'd3, -10);
        rd(24'h30, 8'd0, -10);
        repeat (4) @(posedge clk_i);
        check({7'h00, active_o}, 8'h00);
        test_done();
    end
endmodule // sfdp_basic_param_table_bench

`default_nettype wire
